// >>> src/ssf_regs.svh
// Purpose: Named constants for the startup and fault sequencer
// Assumes: 40 MHz clock, 32-bit AXI4-Lite register bus
// Notes:   Times are in microseconds; cycle counts derive from them
`ifndef SSF_REGS_SVH
`define SSF_REGS_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define SSF_CLK_HZ      40000000
`define SSF_HZ_PER_MHZ  1000000
`define SSF_SCP_US      53000
`define SSF_REC_US      420000
`define SSF_SS_US       1000
`define SSF_SS_STEPS    256
`define SSF_TMR_W       25

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SSF_OFF_CTRL    8'h00
`define SSF_OFF_STATUS  8'h04
`define SSF_OFF_ISTAT   8'h08
`define SSF_OFF_ICLR    8'h0C
`define SSF_OFF_IEN     8'h10
`define SSF_ADDR_W      8

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define SSF_CTRL_RUN    0
`define SSF_CTRL_BYP    1
`define SSF_CTRL_RST    2'h1
`define SSF_IEN_RST     4'h0
`define SSF_EV_W        4
`define SSF_EV_SCP      0
`define SSF_EV_CLAMP    1
`define SSF_EV_UVLO     2
`define SSF_EV_AWAKE    3
`define SSF_ST_CHG      4
`define SSF_ST_SS_LO    8
`define SSF_RESP_OKAY   2'h0
`define SSF_RESP_SLVERR 2'h2

// ****************************************************************
// Comparator input bit positions
// ****************************************************************
`define SSF_N_IN        8
`define SSF_IN_VON      0
`define SSF_IN_VMIN     1
`define SSF_IN_VOFF     2
`define SSF_IN_VLOW     3
`define SSF_IN_LINE     4
`define SSF_IN_FB       5
`define SSF_IN_CLAMP    6
`define SSF_IN_TSD      7

`endif

// >>> src/ssf_pkg.sv
// Purpose: Types shared by the sequencer files
// Assumes: Nothing beyond the constants header
// Notes:   State codes are one-hot
package ssf_pkg;

    // Sequencer states
    typedef enum logic [3:0] {
        ST_OFF  = 4'h1,
        ST_WAIT = 4'h2,
        ST_RUN  = 4'h4,
        ST_REC  = 4'h8
    } ssf_state_t;

endpackage : ssf_pkg

// >>> src/ssf_cmp_if.sv
// Purpose: Carries comparator levels into and out of the synchroniser
// Assumes: One clock domain
// Notes:   raw enters, sync leaves two flops later
`timescale 1ns/10ps
`default_nettype none
interface ssf_cmp_if #(parameter int N = 8);
    logic [N-1:0] raw;
    logic [N-1:0] sync;
    modport sync_side (input raw, output sync);
    modport seq_side  (output raw, input sync);
endinterface : ssf_cmp_if
`default_nettype wire

// >>> src/ssf_sync.sv
// Purpose: Two-flop synchroniser for every comparator level
// Assumes: Inputs may change at any time
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module ssf_sync #(
    parameter int N = 8
) (
    input  wire logic      aclk,
    input  wire logic      aresetn,
    ssf_cmp_if.sync_side   cmp
);
    genvar g;
    // One synchroniser per comparator bit
    generate
        for (g = 0; g < N; g++)
        begin : g_bit
            logic meta_reg;
            logic sync_reg;
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    meta_reg <= 1'b0;
                    sync_reg <= 1'b0;
                end
                else
                begin
                    meta_reg <= cmp.raw[g];
                    sync_reg <= meta_reg;
                end
            end
            assign cmp.sync[g] = sync_reg;
        end
    endgenerate
endmodule : ssf_sync
`default_nettype wire

// >>> src/ssf_sequencer.sv
// Purpose: Startup, self-supply and fault sequencer with AXI4-Lite regs
// Assumes: Comparator outputs arrive as levels; one 40 MHz clock
// Notes:   Long timers are parameters so a bench can shorten them
`timescale 1ns/10ps
`default_nettype none
`include "ssf_regs.svh"

module ssf_sequencer
    import ssf_pkg::*;
#(
    parameter int SCP_CYC = `SSF_SCP_US * (`SSF_CLK_HZ / `SSF_HZ_PER_MHZ),
    parameter int REC_CYC = `SSF_REC_US * (`SSF_CLK_HZ / `SSF_HZ_PER_MHZ),
    parameter int SS_CYC  = `SSF_SS_US * (`SSF_CLK_HZ / `SSF_HZ_PER_MHZ)
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        vcc_on_cmp,
    input  wire logic        vcc_below_min,
    input  wire logic        vcc_below_off,
    input  wire logic        vcc_above_low,
    input  wire logic        line_above_enable,
    input  wire logic        fb_below_fault,
    input  wire logic        clamp_overcurrent,
    input  wire logic        thermal_shutdown,
    input  wire logic        driver_on,
    output logic             hv_src_en,
    output logic             hv_src_high,
    output logic             pulse_en,
    output logic [7:0]       peak_limit_level,
    output logic             irq
);

    // ************************************************************
    // Constants and declarations
    // ************************************************************
    localparam int SS_STEP = SS_CYC / `SSF_SS_STEPS;
    localparam logic [`SSF_TMR_W-1:0] SCP_LAST =
        `SSF_TMR_W'(SCP_CYC - 1);
    localparam logic [`SSF_TMR_W-1:0] REC_LAST =
        `SSF_TMR_W'(REC_CYC - 1);
    localparam logic [15:0] SS_LAST = 16'(SS_STEP - 1);

    ssf_cmp_if #(.N(`SSF_N_IN)) cmp ();

    ssf_state_t             state_reg;
    ssf_state_t             state_next;
    logic [`SSF_TMR_W-1:0]  tmr_reg;
    logic [15:0]            ss_div_reg;
    logic [7:0]             ss_level_reg;
    logic                   charge_reg;
    logic                   hv_high_reg;
    logic [1:0]             ctrl_reg;
    logic [`SSF_EV_W-1:0]   istat_reg;
    logic [`SSF_EV_W-1:0]   ien_reg;
    logic [`SSF_EV_W-1:0]   ev;
    logic                   aw_held_reg;
    logic                   w_held_reg;
    logic [31:0]            awaddr_reg;
    logic [31:0]            wdata_reg;
    logic [3:0]             wstrb_reg;
    logic                   bvalid_reg;
    logic [1:0]             bresp_reg;
    logic                   rvalid_reg;
    logic [31:0]            rdata_reg;
    logic [1:0]             rresp_reg;
    logic                   wr_fire;
    logic [4:0]             wsel;
    logic                   von;
    logic                   vmin;
    logic                   voff;
    logic                   line_ok;
    logic                   err_flag;
    logic                   clamp_oc;
    logic                   tsd;
    logic                   stop_all;
    logic                   ss_tick;

    // Register select, one-hot: ctrl, status, istat, iclr, ien
    function automatic logic [4:0] reg_sel(input logic [31:0] a);
        logic [`SSF_ADDR_W-1:0] o;
        o = a[`SSF_ADDR_W-1:0];
        reg_sel = 5'h0;
        if (a[31:`SSF_ADDR_W] == '0)
        begin
            reg_sel[0] = (o == `SSF_OFF_CTRL);
            reg_sel[1] = (o == `SSF_OFF_STATUS);
            reg_sel[2] = (o == `SSF_OFF_ISTAT);
            reg_sel[3] = (o == `SSF_OFF_ICLR);
            reg_sel[4] = (o == `SSF_OFF_IEN);
        end
    endfunction : reg_sel

    // ************************************************************
    // Comparator synchronisation
    // ************************************************************
    // Comparator levels pass two flops before use
    assign cmp.raw[`SSF_IN_VON]   = vcc_on_cmp;
    assign cmp.raw[`SSF_IN_VMIN]  = vcc_below_min;
    assign cmp.raw[`SSF_IN_VOFF]  = vcc_below_off;
    assign cmp.raw[`SSF_IN_VLOW]  = vcc_above_low;
    assign cmp.raw[`SSF_IN_LINE]  = line_above_enable;
    assign cmp.raw[`SSF_IN_FB]    = fb_below_fault;
    assign cmp.raw[`SSF_IN_CLAMP] = clamp_overcurrent;
    assign cmp.raw[`SSF_IN_TSD]   = thermal_shutdown;

    ssf_sync #(.N(`SSF_N_IN)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cmp     (cmp)
    );

    // Synchronised views; bypass lets software skip line detection
    assign von      = cmp.sync[`SSF_IN_VON];
    assign vmin     = cmp.sync[`SSF_IN_VMIN];
    assign voff     = cmp.sync[`SSF_IN_VOFF];
    assign line_ok  = cmp.sync[`SSF_IN_LINE] | ctrl_reg[`SSF_CTRL_BYP];
    assign err_flag = cmp.sync[`SSF_IN_FB];
    assign clamp_oc = cmp.sync[`SSF_IN_CLAMP];
    assign tsd      = cmp.sync[`SSF_IN_TSD];
    assign stop_all = voff | tsd | ~ctrl_reg[`SSF_CTRL_RUN];

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Next state; undervoltage and thermal stop win over all else
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF:
                if (!stop_all && von)
                    state_next = ST_WAIT;
            ST_WAIT:
                if (stop_all)
                    state_next = ST_OFF;
                else if (line_ok)
                    state_next = ST_RUN;
            ST_RUN:
                if (stop_all)
                    state_next = ST_OFF;
                else if (clamp_oc)
                    state_next = ST_REC;
                else if (err_flag && tmr_reg == SCP_LAST)
                    state_next = ST_REC;
            ST_REC:
                if (stop_all)
                    state_next = ST_OFF;
                else if (tmr_reg == REC_LAST)
                    state_next = ST_WAIT;
            default:
                state_next = ST_OFF;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_reg <= ST_OFF;
        else
            state_reg <= state_next;
    end

    // Shared timer: validation while running, off time in recovery
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            tmr_reg <= '0;
        else if (state_next != state_reg)
            tmr_reg <= '0;
        else if (state_reg == ST_RUN && !err_flag)
            tmr_reg <= '0;
        else if (state_reg == ST_RUN || state_reg == ST_REC)
            tmr_reg <= tmr_reg + 1'b1;
    end

    // ************************************************************
    // Self-supply and startup source
    // ************************************************************
    // Hysteresis: charge from below minimum up to turn-on level
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            charge_reg <= 1'b1;
        else if (state_reg == ST_OFF && !von)
            charge_reg <= 1'b1;
        else if (von)
            charge_reg <= 1'b0;
        else if (vmin)
            charge_reg <= 1'b1;
    end

    // Low current until the supply passes the low threshold
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            hv_high_reg <= 1'b0;
        else
            hv_high_reg <= cmp.sync[`SSF_IN_VLOW];
    end

    // Raw driver level gates the source with no latency
    assign hv_src_en   = charge_reg & ~driver_on;
    assign hv_src_high = hv_high_reg;
    assign pulse_en    = (state_reg == ST_RUN) & line_ok;

    // ************************************************************
    // Soft-start ramp
    // ************************************************************
    assign ss_tick = (ss_div_reg == SS_LAST);

    // Divider yields one step enable per ramp increment
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !pulse_en || ss_tick)
            ss_div_reg <= '0;
        else
            ss_div_reg <= ss_div_reg + 1'b1;
    end

    // Restart from zero on every entry into ST_RUN; a line dropout inside ST_RUN holds the level
    always_ff @(posedge aclk)
    begin
        if (!aresetn || state_reg != ST_RUN)
            ss_level_reg <= '0;
        else if (ss_tick && ss_level_reg != 8'hFF)
            ss_level_reg <= ss_level_reg + 1'b1;
    end

    assign peak_limit_level = ss_level_reg;

    // ************************************************************
    // Interrupts
    // ************************************************************
    assign ev[`SSF_EV_SCP]   = (state_reg == ST_RUN) &&
                               (state_next == ST_REC) && !clamp_oc;
    assign ev[`SSF_EV_CLAMP] = (state_reg == ST_RUN) &&
                               (state_next == ST_REC) && clamp_oc;
    assign ev[`SSF_EV_UVLO]  = (state_reg != ST_OFF) &&
                               (state_next == ST_OFF);
    assign ev[`SSF_EV_AWAKE] = (state_reg == ST_OFF) &&
                               (state_next == ST_WAIT);

    // New events win over a clear in the same cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            istat_reg <= '0;
        else if (wr_fire && wsel[3] && wstrb_reg[0])
            istat_reg <= (istat_reg & ~wdata_reg[`SSF_EV_W-1:0]) | ev;
        else
            istat_reg <= istat_reg | ev;
    end

    assign irq = |(istat_reg & ien_reg);

    // ************************************************************
    // AXI4-Lite slave
    // ************************************************************
    assign wsel          = reg_sel(awaddr_reg);
    assign wr_fire       = aw_held_reg & w_held_reg & ~bvalid_reg;
    assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
    assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // Address and data are caught independently, in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= '0;
            wdata_reg   <= '0;
            wstrb_reg   <= '0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_held_reg <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_held_reg <= 1'b0;
        end
    end

    // Write response; status is read-only so writes there fail
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `SSF_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (wsel[0] | wsel[3] | wsel[4]) ?
                          `SSF_RESP_OKAY : `SSF_RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_reg <= 1'b0;
    end

    // Control and enable registers, low byte lane only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_reg <= `SSF_CTRL_RST;
            ien_reg  <= `SSF_IEN_RST;
        end
        else if (wr_fire && wstrb_reg[0])
        begin
            if (wsel[0])
                ctrl_reg <= wdata_reg[1:0];
            if (wsel[4])
                ien_reg <= wdata_reg[`SSF_EV_W-1:0];
        end
    end

    // Read data; clear register reads as zero
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= `SSF_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= '0;
            rresp_reg  <= `SSF_RESP_OKAY;
            case (reg_sel(s_axi_araddr))
                5'h01: rdata_reg[1:0] <= ctrl_reg;
                5'h02:
                begin
                    rdata_reg[3:0]  <= state_reg;
                    rdata_reg[`SSF_ST_CHG] <= charge_reg;
                    rdata_reg[`SSF_ST_SS_LO +: 8] <= ss_level_reg;
                end
                5'h04: rdata_reg[`SSF_EV_W-1:0] <= istat_reg;
                5'h08: rdata_reg <= '0;
                5'h10: rdata_reg[`SSF_EV_W-1:0] <= ien_reg;
                default: rresp_reg <= `SSF_RESP_SLVERR;
            endcase
        end
        else if (s_axi_rready)
            rvalid_reg <= 1'b0;
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_run_fault_end;
        state_reg == ST_RUN && err_flag && !stop_all && !clamp_oc
        && tmr_reg == SCP_LAST;
    endsequence

    sequence s_rec_end;
        state_reg == ST_REC && !stop_all && tmr_reg == REC_LAST;
    endsequence

    AST_WAKE: assert property (
        state_reg == ST_OFF && von && !stop_all |=> state_reg == ST_WAIT
        ##0 !charge_reg)
        else $error("no wake at turn-on level");
    AST_LINE: assert property (
        pulse_en |-> state_reg == ST_RUN
        && (cmp.sync[`SSF_IN_LINE] || ctrl_reg[`SSF_CTRL_BYP]))
        else $error("pulses without line level");
    AST_HYST: assert property (
        vmin && !von |=> charge_reg ##1 (charge_reg || $past(von)))
        else $error("self-supply hysteresis broken");
    AST_STOP: assert property (
        voff |=> state_reg == ST_OFF ##1 !pulse_en)
        else $error("no stop below turn-off");
    AST_DRV: assert property (
        driver_on |-> !hv_src_en)
        else $error("source on with driver on");
    AST_CLAMP: assert property (
        state_reg == ST_RUN && clamp_oc && !stop_all
        |=> state_reg == ST_REC && tmr_reg == '0 && !pulse_en)
        else $error("clamp fault not handled");
    AST_LOWCUR: assert property (
        !cmp.sync[`SSF_IN_VLOW] |=> !hv_src_high)
        else $error("high current below low level");
    AST_RAMP: assert property (
        state_reg == ST_RUN && $past(state_reg) == ST_RUN
        |-> ss_level_reg >= $past(ss_level_reg))
        else $error("soft-start ramp fell");
    AST_SCP: assert property (
        s_run_fault_end |=> state_reg == ST_REC)
        else $error("validated fault kept switching");
    AST_RETRY: assert property (
        s_rec_end |=> state_reg == ST_WAIT)
        else $error("no restart after off time");
    AST_CLEAR: assert property (
        state_reg == ST_RUN && !err_flag && !stop_all && !clamp_oc
        |=> tmr_reg == '0 && state_reg == ST_RUN)
        else $error("timer not cleared on fault removal");

endmodule : ssf_sequencer
`default_nettype wire

// >>> tb/ssf_partner.sv
// Purpose: Power switch stage seen from the sequencer
// Assumes: One clock; the driver follows pulse_en
// Notes:   Toggles every clock while allowed, as a fast switch would
`timescale 1ns/10ps
`default_nettype none
module ssf_partner (
    input  wire logic aclk,
    input  wire logic pulse_en,
    output var logic  driver_on
);
    // Off at once when pulses stop, so the source gate sees both levels
    always_ff @(posedge aclk)
    begin
        driver_on <= pulse_en & ~driver_on;
    end
endmodule : ssf_partner
`default_nettype wire

// >>> tb/ssf_sequencer_tb.sv
// Purpose: Self-checking bench for the startup and fault sequencer
// Assumes: Timers shortened to 20, 50 and 512 cycles
// Notes:   Expected values are worked out here, never read back
`timescale 1ns/10ps
`default_nettype none
`define CK(s,e,g) begin tests_run++; if ((g)!==(e)) begin n_fail++; \
$display("unexpected %s exp %0h got %0h", s, e, g); end end
`define WT(c,n) begin k=0; do begin @(negedge aclk); k++; end \
while (!(c) && k<n); end
module ssf_sequencer_tb;
    import ssf_pkg::*;
    logic aclk=0, aresetn=0, awv=0, wv=0, bry=0, arv=0, rry=0;
    logic [31:0] awa=0, wd=0, ara=0, rdat, v, ien;
    logic awr, wr, bv, arr, rv, hv_en, hv_hi, pls, irq, drv;
    logic [1:0] br, rr, rsp;
    logic [7:0] lvl;
    logic von=0, bmin=0, boff=0, alow=0, line=0, fb=0, clmp=0, tsd=0;
    int n_fail=0, tests_run=0, k, cyc=0, seed=32'h9d241642;
    // Event model: interrupt status expected after the clear
    int ist_m=0;
    ssf_sequencer #(.SCP_CYC(20), .REC_CYC(50), .SS_CYC(512)) dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rry), .vcc_on_cmp(von), .vcc_below_min(bmin),
        .vcc_below_off(boff), .vcc_above_low(alow),
        .line_above_enable(line), .fb_below_fault(fb),
        .clamp_overcurrent(clmp), .thermal_shutdown(tsd),
        .driver_on(drv), .hv_src_en(hv_en), .hv_src_high(hv_hi),
        .pulse_en(pls), .peak_limit_level(lvl), .irq(irq));
    ssf_partner sw (.aclk(aclk), .pulse_en(pls), .driver_on(drv));
    // Clock and hang guard
    always #12.5 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (n_fail == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    // Readies sampled at the falling edge, stable until the next rise
    task automatic axw(input logic [31:0] a, d, output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge aclk);
        awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
        do
        begin
            @(negedge aclk);
            ta = awv & awr; tw = wv & wr; tb = bv; r = br;
            @(posedge aclk);
            if (ta) awv <= 0;
            if (tw) wv <= 0;
        end
        while (!tb);
        bry <= 0;
    endtask : axw
    task automatic axr(input logic [31:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        logic ta, tb;
        @(posedge aclk);
        ara <= a; arv <= 1; rry <= 1;
        do
        begin
            @(negedge aclk);
            ta = arv & arr; tb = rv; d = rdat; r = rr;
            @(posedge aclk);
            if (ta) arv <= 0;
        end
        while (!tb);
        rry <= 0;
    endtask : axr
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        @(negedge aclk);
        `CK("src_en", 1'b1, hv_en)
        `CK("src_high", 1'b0, hv_hi)
        `CK("pulse", 1'b0, pls)
        axr(32'h0, v, rsp);
        `CK("ctrl", 32'h1, v)
        axr(32'h40, v, rsp);
        `CK("unmapped", 2'h2, rsp)
        axw(32'h4, 32'h0, rsp);
        `CK("ro_write", 2'h2, rsp)
        ien = 32'($random(seed)) & 32'hF;
        axw(32'h10, ien, rsp);
        axr(32'h10, v, rsp);
        `CK("ien", ien, v)
        axw(32'h10, 32'hF, rsp);
        // Power-up: low then high source current, then wake
        @(posedge aclk) alow <= 1;
        `WT(hv_hi, 6) `CK("src_high", 1'b1, hv_hi)
        @(posedge aclk) von <= 1;
        line <= 1;
        `WT(pls, 8) `CK("pulse", 1'b1, pls)
        `CK("src_en", 1'b0, hv_en)
        `CK("irq", 1'b1, irq)
        axr(32'h8, v, rsp);
        `CK("wake", 1'b1, v[3])
        axw(32'hC, 32'hF, rsp);
        `WT(1'b0, 2) `CK("irq_clr", 1'b0, irq)
        `WT(lvl == 8'hFF, 700) `CK("level", 8'hFF, lvl)
        // Self-supply while switching: source gated by the driver
        @(posedge aclk) von <= 0;
        bmin <= 1;
        repeat (4) @(negedge aclk);
        for (int i = 0; i < 6; i++)
        begin
            @(negedge aclk);
            `CK("src_gate", ~drv, hv_en)
        end
        @(posedge aclk) bmin <= 0;
        `WT(1'b0, 4) `CK("src_hold", ~drv, hv_en)
        @(posedge aclk) von <= 1;
        `WT(1'b0, 4) `CK("src_off", 1'b0, hv_en)
        @(posedge aclk) line <= 0;
        `WT(!pls, 6) `CK("pulse", 1'b0, pls)
        @(posedge aclk) line <= 1;
        `WT(pls, 6) `CK("pulse", 1'b1, pls)
        // Persistent overload gives two burst rounds
        @(posedge aclk) fb <= 1;
        for (int i = 0; i < 2; i++)
        begin
            `WT(1'b0, 15) `CK("pulse", 1'b1, pls)
            `WT(!pls, 10) `CK("pulse", 1'b0, pls)
            `WT(1'b0, 40) `CK("pulse", 1'b0, pls)
            `WT(pls, 20) `CK("pulse", 1'b1, pls)
        end
        `CK("irq", 1'b1, irq)
        ist_m |= 1;
        @(posedge aclk) fb <= 0;
        `WT(1'b0, 60) `CK("pulse", 1'b1, pls)
        @(posedge aclk) clmp <= 1;
        `WT(!pls, 5) `CK("pulse", 1'b0, pls)
        ist_m |= 2;
        @(posedge aclk) clmp <= 0;
        `WT(1'b0, 40) `CK("pulse", 1'b0, pls)
        `WT(pls, 20) `CK("pulse", 1'b1, pls)
        // Undervoltage stop, then restart held off by a low line
        @(posedge aclk) boff <= 1;
        `WT(!pls, 5) `CK("pulse", 1'b0, pls)
        axr(32'h4, v, rsp);
        `CK("state", 4'h1, v[3:0])
        ist_m |= 4;
        @(posedge aclk) boff <= 0;
        line <= 0;
        `WT(1'b0, 20) `CK("pulse", 1'b0, pls)
        @(posedge aclk) line <= 1;
        `WT(pls, 10) `CK("pulse", 1'b1, pls)
        ist_m |= 8;
        // Thermal stop, then line bypass, then run disabled by software
        @(posedge aclk) tsd <= 1;
        `WT(!pls, 5) `CK("pulse", 1'b0, pls)
        @(posedge aclk) tsd <= 0;
        line <= 0;
        `WT(1'b0, 10) `CK("pulse", 1'b0, pls)
        axw(32'h0, 32'h3, rsp);
        `WT(pls, 4) `CK("pulse", 1'b1, pls)
        axw(32'h0, 32'h2, rsp);
        `WT(!pls, 4) `CK("pulse", 1'b0, pls)
        axr(32'h4, v, rsp);
        `CK("state", 4'h1, v[3:0])
        axr(32'h8, v, rsp);
        `CK("istat", ist_m, v)
        end_of_test();
    end
endmodule : ssf_sequencer_tb
`default_nettype wire
